// [flow_totalizer_control.sv]
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
module flow_totalizer_control
  import flow_totalizer_pkg::*;
(
  input  wire logic                                   clk_i,
  input  wire logic                                   rst_i,
  input  wire logic                                   cyc_i,
  input  wire logic                                   stb_i,
  input  wire logic                                   we_i,
  input  wire logic [flow_totalizer_pkg::ADR_W-1:0]   adr_i,
  input  wire logic [3:0]                             sel_i,
  input  wire logic [flow_totalizer_pkg::DAT_W-1:0]   dat_i,
  output      logic [flow_totalizer_pkg::DAT_W-1:0]   dat_o,
  output      logic                                   ack_o,
  input  wire logic [flow_totalizer_pkg::PRF_W-1:0]   profile_i,
  input  wire logic [flow_totalizer_pkg::NUM_TOT-1:0] nv_mask_i,
  input  wire logic                                   upd_valid_i,
  input  wire logic [flow_totalizer_pkg::DAT_W-1:0]   upd_value_i,
  output      logic [flow_totalizer_pkg::DAT_W-1:0]   sel_value_o,
  output      logic                                   sel_enabled_o,
  output      logic                                   nv_mask_wr_o,
  output      logic [flow_totalizer_pkg::NUM_TOT-1:0] nv_mask_o,
  output      logic [flow_totalizer_pkg::NUM_TOT-1:0] save_allow_o,
  output      logic                                   restore_req_o,
  output      logic [15:0]                            restore_index_o,
  output      logic                                   init_done_o
);
  import flow_totalizer_pkg::*;

  // bus and control state
  ctl_state_t           state_r,      state_nxt;
  logic                 ack_r,        ack_nxt;
  logic [DAT_W-1:0]     dat_r,        dat_nxt;
  logic [NUM_TOT-1:0]   resettable_r, resettable_nxt;
  logic [NUM_TOT-1:0]   enable_r,     enable_nxt;
  logic [NUM_TOT-1:0]   mask_r,       mask_nxt;
  logic                 mask_wr_r,    mask_wr_nxt;
  logic                 restore_r,    restore_nxt;
  logic [15:0]          rindex_r,     rindex_nxt;
  logic [DAT_W-1:0]     accum_r   [NUM_TOT];
  logic [DAT_W-1:0]     accum_nxt [NUM_TOT];

  // decoded request
  logic                 req;
  logic                 wr;
  logic [IDX_W-1:0]     idx;
  logic [DAT_W-1:0]     wdat;
  logic [NUM_TOT-1:0]   sel_onehot;
  logic [NUM_TOT-1:0]   clr_vec;
  logic                 run;

  // one new request per ack, slave answers one edge later
  assign req  = cyc_i & stb_i & ~ack_r;
  assign wr   = req & we_i & (sel_i != 4'h0);
  assign idx  = adr_i[ADR_W-1:2];
  assign wdat = lane_mask(sel_i, dat_i);
  assign run  = (state_r == ST_RUN);

  // active totalizer follows the profile number
  assign sel_onehot = NUM_TOT'(1) << profile_i;

  // clear sources, gated by the lock flags where they apply
  always_comb begin
    clr_vec = '0;
    if (state_r == ST_INIT) begin
      clr_vec = nv_mask_i;
    end else if (wr) begin
      case (idx)
        IDX_BULK_CLR: clr_vec = wdat[NUM_TOT-1:0] & resettable_r;
        IDX_SEL_CLR:  clr_vec = sel_onehot & resettable_r;
        IDX_VALUE:    clr_vec = (wdat == '0) ? (sel_onehot & resettable_r) : '0;
        default:      clr_vec = '0;
      endcase
    end
  end

  // per-totalizer value update, clear has priority over flow updates
  genvar g;
  generate
    for (g = 0; g < NUM_TOT; g++) begin : g_tot
      always_comb begin
        if (clr_vec[g]) begin
          accum_nxt[g] = VALUE_RST;
        end else if (run && upd_valid_i && sel_onehot[g] && enable_r[g]) begin
          accum_nxt[g] = upd_value_i;
        end else begin
          accum_nxt[g] = accum_r[g];
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          accum_r[g] <= VALUE_RST;
        end else begin
          accum_r[g] <= accum_nxt[g];
        end
      end
    end
  endgenerate

  // startup sequencing and register writes
  always_comb begin
    state_nxt      = state_r;
    resettable_nxt = resettable_r;
    enable_nxt     = enable_r;
    mask_nxt       = mask_r;
    mask_wr_nxt    = 1'b0;
    restore_nxt    = 1'b0;
    rindex_nxt     = rindex_r;
    case (state_r)
      ST_INIT: begin
        mask_nxt  = nv_mask_i;
        state_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (wr) begin
          case (idx)
            IDX_ENABLE: begin
              if (wdat != '0) begin
                enable_nxt = enable_r | sel_onehot;
              end else begin
                enable_nxt = enable_r & ~sel_onehot;
              end
            end
            IDX_RESETTABLE: resettable_nxt = wdat[NUM_TOT-1:0];
            IDX_STARTUP_MASK: begin
              mask_nxt    = wdat[NUM_TOT-1:0];
              mask_wr_nxt = 1'b1;
            end
            IDX_RESTORE: begin
              if (wdat[15:0] < NUM_IMAGES) begin
                restore_nxt = 1'b1;
                rindex_nxt  = wdat[15:0];
              end
            end
            default: ;
          endcase
        end
      end
      default: state_nxt = ST_INIT;
    endcase
  end

  // read mux and acknowledge
  always_comb begin
    ack_nxt = req;
    dat_nxt = '0;
    if (req && !we_i) begin
      case (idx)
        IDX_VALUE:        dat_nxt = accum_r[profile_i];
        IDX_ENABLE:       dat_nxt = {31'h0000_0000, enable_r[profile_i]};
        IDX_RESETTABLE:   dat_nxt = {16'h0000, resettable_r};
        IDX_STARTUP_MASK: dat_nxt = {16'h0000, mask_r};
        default:          dat_nxt = '0;
      endcase
    end
  end

  // control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r      <= ST_INIT;
      ack_r        <= 1'b0;
      dat_r        <= '0;
      resettable_r <= RESETTABLE_RST;
      enable_r     <= ENABLE_RST;
      mask_r       <= MASK_RST;
      mask_wr_r    <= 1'b0;
      restore_r    <= 1'b0;
      rindex_r     <= INDEX_RST;
    end else begin
      state_r      <= state_nxt;
      ack_r        <= ack_nxt;
      dat_r        <= dat_nxt;
      resettable_r <= resettable_nxt;
      enable_r     <= enable_nxt;
      mask_r       <= mask_nxt;
      mask_wr_r    <= mask_wr_nxt;
      restore_r    <= restore_nxt;
      rindex_r     <= rindex_nxt;
    end
  end

  // outputs
  assign ack_o           = ack_r;
  assign dat_o           = dat_r;
  assign sel_value_o     = accum_r[profile_i];
  assign sel_enabled_o   = enable_r[profile_i];
  assign nv_mask_wr_o    = mask_wr_r;
  assign nv_mask_o       = mask_r;
  assign save_allow_o    = ~mask_r;
  assign restore_req_o   = restore_r;
  assign restore_index_o = rindex_r;
  assign init_done_o     = run;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held for more than one cycle");

  a_bulk_clear_hit: assert property (
    (run && wr && idx == IDX_BULK_CLR && wdat[2] && resettable_r[2]) |=> accum_r[2] == '0)
    else $error("bulk clear missed an unlocked totalizer");

  a_bulk_lock_zero: assert property (
    (run && wr && idx == IDX_BULK_CLR && !resettable_r[0] && !(upd_valid_i && sel_onehot[0]))
    |=> accum_r[0] == $past(accum_r[0]))
    else $error("locked totalizer was cleared");

  a_lock_after_reset: assert property (
    $fell(rst_i) |-> resettable_r == 16'hFFFE)
    else $error("lock flags wrong after reset");

  a_sel_clear: assert property (
    (run && wr && idx == IDX_SEL_CLR && resettable_r[profile_i]) ##1 $stable(profile_i)
    |-> sel_value_o == '0)
    else $error("selected clear did not clear");

  a_disabled_hold: assert property (
    (run && !enable_r[profile_i] && clr_vec == '0) ##1 $stable(profile_i)
    |-> sel_value_o == $past(sel_value_o))
    else $error("disabled totalizer changed");

  a_mask_saved: assert property (
    (run && wr && idx == IDX_STARTUP_MASK) |=> nv_mask_wr_o && nv_mask_o == $past(wdat[15:0]) ##1 !nv_mask_wr_o)
    else $error("mask not saved on write");

  a_restore_valid: assert property (
    restore_req_o |-> restore_index_o < NUM_IMAGES)
    else $error("restore issued for missing image");

  a_restore_keeps: assert property (
    (run && wr && idx == IDX_RESTORE && !upd_valid_i) |=> accum_r[profile_i] == $past(accum_r[profile_i]) || $changed(profile_i))
    else $error("restore disturbed a totalizer");

  a_enable_write: assert property (
    (run && wr && idx == IDX_ENABLE && wdat != '0) ##1 $stable(profile_i) |-> sel_enabled_o)
    else $error("enable write not applied");

  // bulk clear and lock flag write checks
  a_bulk_zero_bit: assert property (
    (run && wr && idx == IDX_BULK_CLR && !wdat[3] && !(upd_valid_i && sel_onehot[3] && enable_r[3]))
    |=> accum_r[3] == $past(accum_r[3]))
    else $error("bulk clear hit a totalizer with a zero bit");

  a_bulk_no_side: assert property (
    (run && wr && idx == IDX_BULK_CLR)
    |=> enable_r == $past(enable_r) && resettable_r == $past(resettable_r) && nv_mask_o == $past(nv_mask_o))
    else $error("bulk clear changed other state");

  a_clear_disabled: assert property (
    (run && wr && idx == IDX_BULK_CLR && wdat[2] && resettable_r[2] && !enable_r[2]) |=> accum_r[2] == '0)
    else $error("disabled totalizer not cleared");

  a_lock_write: assert property (
    (run && wr && idx == IDX_RESETTABLE) |=> resettable_r == $past(wdat[NUM_TOT-1:0]))
    else $error("lock flags not written");

  // startup checks
  a_init_mask: assert property (
    $fell(rst_i) |=> nv_mask_o == $past(nv_mask_i))
    else $error("startup mask not loaded");

  a_init_done: assert property (
    $fell(rst_i) |-> !init_done_o ##1 init_done_o)
    else $error("startup cycle not completed");

  // selected totalizer checks
  a_update_apply: assert property (
    (run && upd_valid_i && enable_r[profile_i] && clr_vec == '0) ##1 $stable(profile_i)
    |-> sel_value_o == $past(upd_value_i))
    else $error("flow update not applied");

  a_value_zero: assert property (
    (run && wr && idx == IDX_VALUE && wdat == '0 && resettable_r[profile_i]) ##1 $stable(profile_i)
    |-> sel_value_o == '0)
    else $error("zero value write did not clear");

  a_value_nonzero: assert property (
    (run && wr && idx == IDX_VALUE && wdat != '0 && !(upd_valid_i && enable_r[profile_i]))
    ##1 $stable(profile_i) |-> sel_value_o == $past(sel_value_o))
    else $error("nonzero value write changed the totalizer");

  a_sel_locked: assert property (
    (run && wr && idx == IDX_SEL_CLR && !resettable_r[profile_i] && !(upd_valid_i && enable_r[profile_i]))
    ##1 $stable(profile_i) |-> sel_value_o == $past(sel_value_o))
    else $error("locked selected totalizer was cleared");

  a_disable_write: assert property (
    (run && wr && idx == IDX_ENABLE && wdat == '0) ##1 $stable(profile_i) |-> !sel_enabled_o)
    else $error("disable write not applied");

  // read and acknowledge checks
  a_ack_answer: assert property (
    req |=> ack_o)
    else $error("request not acknowledged");

  a_read_idle: assert property (
    !ack_o |-> dat_o == '0)
    else $error("read data shown outside ack");

  a_value_read: assert property (
    (req && !we_i && idx == IDX_VALUE) |=> ack_o && dat_o == $past(sel_value_o))
    else $error("value read returned wrong word");

  a_enable_read: assert property (
    (run && req && !we_i && idx == IDX_ENABLE) |=> dat_o == {31'h0000_0000, $past(sel_enabled_o)})
    else $error("enable read returned wrong word");

  a_mask_read: assert property (
    (run && req && !we_i && idx == IDX_STARTUP_MASK) |=> dat_o == {16'h0000, nv_mask_o})
    else $error("mask read returned wrong word");

  // restore checks
  a_restore_pulse: assert property (
    (run && wr && idx == IDX_RESTORE && wdat[15:0] < NUM_IMAGES)
    |=> restore_req_o && restore_index_o == $past(wdat[15:0]))
    else $error("valid restore not requested");

  a_restore_bad: assert property (
    (run && wr && idx == IDX_RESTORE && wdat[15:0] >= NUM_IMAGES) |=> !restore_req_o)
    else $error("invalid restore was requested");

  // main scenarios
  c_bulk_clear:  cover property (run && wr && idx == IDX_BULK_CLR);
  c_restore:     cover property (restore_req_o);
  c_value_clear: cover property (run && wr && idx == IDX_VALUE && wdat == '0 && resettable_r[profile_i]);
  c_sel_clear:   cover property (run && wr && idx == IDX_SEL_CLR && resettable_r[profile_i]);
  c_mask_save:   cover property (nv_mask_wr_o);

endmodule : flow_totalizer_control

// [flow_totalizer_pkg.sv]
package flow_totalizer_pkg;

  // geometry of the bank and the bus
  localparam int NUM_TOT = 16;
  localparam int ADR_W   = 18;
  localparam int DAT_W   = 32;
  localparam int PRF_W   = 4;
  localparam int IDX_W   = 16;

  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_VALUE        = 16'h0004;
  localparam logic [IDX_W-1:0] IDX_BULK_CLR     = 16'h1F10;
  localparam logic [IDX_W-1:0] IDX_ENABLE       = 16'h1F11;
  localparam logic [IDX_W-1:0] IDX_RESETTABLE   = 16'h1F12;
  localparam logic [IDX_W-1:0] IDX_STARTUP_MASK = 16'h1F20;
  localparam logic [IDX_W-1:0] IDX_SEL_CLR      = 16'h1F50;
  localparam logic [IDX_W-1:0] IDX_RESTORE      = 16'hFFFC;

  // reset values
  localparam logic [NUM_TOT-1:0] RESETTABLE_RST = 16'hFFFE;
  localparam logic [NUM_TOT-1:0] ENABLE_RST     = 16'h0000;
  localparam logic [DAT_W-1:0]   VALUE_RST      = 32'h0000_0000;
  localparam logic [NUM_TOT-1:0] MASK_RST       = 16'h0000;
  localparam logic [15:0]        INDEX_RST      = 16'h0000;

  // number of factory images present, plain default
  localparam logic [15:0] NUM_IMAGES = 16'h0002;

  // controller states
  typedef enum logic [1:0] {
    ST_INIT = 2'b01,
    ST_RUN  = 2'b10
  } ctl_state_t;

  // applies wishbone byte selects to write data
  function automatic logic [DAT_W-1:0] lane_mask(input logic [3:0] sel, input logic [DAT_W-1:0] d);
    logic [DAT_W-1:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return d & m;
  endfunction : lane_mask

endpackage : flow_totalizer_pkg

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import flow_totalizer_pkg::*;
  logic               clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, pw, pr;
  logic               upd_valid_i, sel_enabled_o, nv_mask_wr_o, restore_req_o, init_done_o;
  logic [ADR_W-1:0]   adr_i;
  logic [3:0]         sel_i;
  logic [DAT_W-1:0]   dat_i, dat_o, upd_value_i, sel_value_o, q;
  logic [PRF_W-1:0]   profile_i;
  logic [NUM_TOT-1:0] nv_mask_i, nv_mask_o, save_allow_o;
  logic [15:0]        restore_index_o;
  int                 n_fail = 0;
  int                 samples_checked = 0;

  flow_totalizer_control i_flow_totalizer_control (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .profile_i(profile_i),
    .nv_mask_i(nv_mask_i), .upd_valid_i(upd_valid_i), .upd_value_i(upd_value_i),
    .sel_value_o(sel_value_o), .sel_enabled_o(sel_enabled_o), .nv_mask_wr_o(nv_mask_wr_o),
    .nv_mask_o(nv_mask_o), .save_allow_o(save_allow_o), .restore_req_o(restore_req_o),
    .restore_index_o(restore_index_o), .init_done_o(init_done_o));

  // free-running clock, 8 ns period
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one classic wishbone cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [15:0] idx, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= {idx, 2'b00}; dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    r = dat_o;
    pw = nv_mask_wr_o;
    pr = restore_req_o;
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
  endtask : wb

  // hold reset for eight cycles, then watch the startup cycle pass
  task automatic do_reset;
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk({31'h0, init_done_o}, 32'h0);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({31'h0, init_done_o}, 32'h0);
    @(posedge clk_i);
    chk({31'h0, init_done_o}, 32'h1);
  endtask : do_reset

  // enable a totalizer and hand it a new accumulated value
  task automatic load(input logic [3:0] p, input logic [31:0] v);
    profile_i <= p;
    wb(1'b1, IDX_ENABLE, 32'h0000_0001, q);
    upd_valid_i <= 1'b1; upd_value_i <= v;
    @(posedge clk_i);
    upd_valid_i <= 1'b0;
  endtask : load

  // select a totalizer and compare its value once the select has settled
  task automatic sv(input logic [3:0] p, input logic [31:0] e);
    profile_i <= p;
    repeat (2) @(posedge clk_i);
    chk(sel_value_o, e);
  endtask : sv

  task automatic t_reset;
    wb(1'b0, IDX_RESETTABLE, 32'h0, q); chk(q, 32'h0000_FFFE);
    wb(1'b0, IDX_STARTUP_MASK, 32'h0, q); chk(q, 32'h0000_8002);
    chk({16'h0, save_allow_o}, 32'h0000_7FFD);
    wb(1'b0, IDX_ENABLE, 32'h0, q); chk(q, 32'h0);
    wb(1'b0, 16'h0100, 32'h0, q); chk(q, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_bulk;
    load(4'h0, 32'h3F80_0000); load(4'h2, 32'h4000_0000); load(4'hF, 32'h4040_0000);
    chk({31'h0, sel_enabled_o}, 32'h1);
    profile_i <= 4'h2;
    wb(1'b1, IDX_ENABLE, 32'h0, q);
    chk({31'h0, sel_enabled_o}, 32'h0);
    load(4'h3, 32'h4080_0000);
    @(posedge clk_i);
    profile_i <= 4'h2;
    upd_valid_i <= 1'b1; upd_value_i <= 32'h4110_0000;
    @(posedge clk_i);
    upd_valid_i <= 1'b0;
    sv(4'h2, 32'h4000_0000);
    wb(1'b1, IDX_BULK_CLR, 32'hFFFF_8005, q);
    sv(4'h0, 32'h3F80_0000);
    sv(4'h2, 32'h0);
    sv(4'h3, 32'h4080_0000);
    sv(4'hF, 32'h0);
    wb(1'b0, IDX_VALUE, 32'h0, q); chk(q, 32'h0);
    profile_i <= 4'h3;
    wb(1'b0, IDX_VALUE, 32'h0, q); chk(q, 32'h4080_0000);
    $display("test bulk done");
  endtask : t_bulk

  task automatic t_sel;
    profile_i <= 4'h3;
    wb(1'b1, IDX_VALUE, 32'h0000_0001, q); sv(4'h3, 32'h4080_0000);
    wb(1'b1, IDX_VALUE, 32'h0, q); sv(4'h3, 32'h0);
    load(4'h3, 32'h4100_0000); sv(4'h3, 32'h4100_0000);
    wb(1'b1, IDX_SEL_CLR, 32'h0000_ABCD, q); sv(4'h3, 32'h0);
    profile_i <= 4'h0;
    wb(1'b1, IDX_SEL_CLR, 32'h0000_0001, q); sv(4'h0, 32'h3F80_0000);
    wb(1'b1, IDX_VALUE, 32'h0, q); sv(4'h0, 32'h3F80_0000);
    $display("test select done");
  endtask : t_sel

  task automatic t_mask;
    wb(1'b1, IDX_STARTUP_MASK, 32'hFFFF_C004, q); chk({31'h0, pw}, 32'h1);
    chk({16'h0, nv_mask_o}, 32'h0000_C004);
    wb(1'b0, IDX_STARTUP_MASK, 32'h0, q); chk(q, 32'h0000_C004);
    chk({16'h0, save_allow_o}, 32'h0000_3FFB);
    $display("test mask done");
  endtask : t_mask

  task automatic t_restore;
    wb(1'b1, IDX_RESTORE, 32'h0000_0001, q); chk({31'h0, pr}, 32'h1);
    chk({16'h0, restore_index_o}, 32'h0000_0001);
    wb(1'b1, IDX_RESTORE, 32'h0000_0000, q); chk({31'h0, pr}, 32'h1);
    chk({16'h0, restore_index_o}, 32'h0000_0000);
    wb(1'b1, IDX_RESTORE, 32'h0000_0002, q); chk({31'h0, pr}, 32'h0);
    chk({16'h0, restore_index_o}, 32'h0000_0000);
    sv(4'h0, 32'h3F80_0000);
    $display("test restore done");
  endtask : t_restore

  // unlock profile 0, then a mid-run reset restores the lock and the stored mask
  task automatic t_lock;
    wb(1'b1, IDX_RESETTABLE, 32'h0000_FFFF, q);
    wb(1'b0, IDX_RESETTABLE, 32'h0, q); chk(q, 32'h0000_FFFF);
    wb(1'b1, IDX_BULK_CLR, 32'h0000_0001, q); sv(4'h0, 32'h0);
    load(4'h1, 32'h4120_0000); sv(4'h1, 32'h4120_0000);
    do_reset;
    wb(1'b0, IDX_RESETTABLE, 32'h0, q); chk(q, 32'h0000_FFFE);
    wb(1'b0, IDX_STARTUP_MASK, 32'h0, q); chk(q, 32'h0000_8002);
    sv(4'h1, 32'h0);
    $display("test lock done");
  endtask : t_lock

  // main sequence
  initial begin
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0; adr_i <= '0; sel_i <= 4'hF;
    dat_i <= '0; profile_i <= '0; nv_mask_i <= 16'h8002; upd_valid_i <= 1'b0; upd_value_i <= '0;
    do_reset;
    t_reset;
    t_bulk;
    t_sel;
    t_mask;
    t_restore;
    t_lock;
    test_done;
  end

  // watchdog against a hung bus cycle
  initial begin
    #200000;
    n_fail++;
    test_done;
  end
endmodule : tb_top
